/* rtl/rxsn_slot_timer.v */
`timescale 1ns/100ps
`include "rxsn_defs.vh"
module rxsn_slot_timer (
	input wire mclk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ch1FlagDet,
	input wire ch2FlagDet,
	input wire utcPulse,
	output reg rfEnableCh1,
	output reg rfEnableCh2,
	output reg rxActiveCh1,
	output reg rxActiveCh2,
	output reg txStartPulse
);
	reg [2:0] ctrl_reg;
	reg [10:0] sleep_reg, wake_reg, trig_reg, maxAuto_reg, txStart_reg;
	reg [11:0] slotNudge_reg;
	reg [10:0] sampNudge_reg;
	reg nudgePend_reg;
	reg [1:0] rx1Ctl_reg, rx2Ctl_reg;
	reg [11:0] slot_reg;
	reg [10:0] sample_reg;
	reg [7:0] tick_reg;
	reg [22:0] flag1_reg, flag2_reg;
	reg [11:0] autoNudge_reg;
	reg autoPend_reg;
	wire [1:0] asleep;
	wire [1:0] gotFlag;
	wire [1:0] flagDet;
	wire [3:0] chCtl;
	wire tick, slotStart, atTrig, apbWr, apbRd;
	wire [11:0] sampWide, nudgeSamp, sampSum, slotSum;
	wire [11:0] calc, calcAbs, clamped;
	assign flagDet = {ch2FlagDet, ch1FlagDet};
	assign chCtl = {rx2Ctl_reg, rx1Ctl_reg};
	assign tick = (tick_reg == `RXSN_TICK_LAST);
	assign slotStart = tick && sample_reg == `RXSN_SAMPLE_MAX;
	assign atTrig = tick && sample_reg == trig_reg;
	assign apbWr = psel && penable && pwrite && !pready;
	assign apbRd = psel && !penable && !pwrite;
	assign sampWide = {1'b0, sample_reg};
	assign calc = (sample_reg >= 11'd320 && sample_reg < 11'd960) ?
		12'd640 - sampWide : 12'd0 - sampWide;
	assign calcAbs = calc[11] ? 12'd0 - calc : calc;
	assign clamped = (calcAbs <= {1'b0, maxAuto_reg}) ? calc :
		(calc[11] ? 12'd0 - {1'b0, maxAuto_reg} : {1'b0, maxAuto_reg});
	assign nudgeSamp = (ctrl_reg[1:0] == `RXSN_MODE_TRACK) ?
		(autoPend_reg ? autoNudge_reg : 12'd0) :
		(nudgePend_reg ? {sampNudge_reg[10], sampNudge_reg} : 12'd0);
	assign sampSum = sampWide + nudgeSamp + 12'd1;
	assign slotSum = slot_reg + slotNudge_reg;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			rxsn_chan_sleep u_sleep (
				.mclk(mclk),
				.rst_n(rst_n),
				.sleepOn(ctrl_reg[`RXSN_B_SLEEPEN]),
				.chanCtl(chCtl[2*g+1:2*g]),
				.slotStart(slotStart),
				.flagDet(flagDet[g]),
				.sampleCount(sample_reg),
				.sleepSample(sleep_reg),
				.wakeSample(wake_reg),
				.asleep_reg(asleep[g]),
				.gotFlag_reg(gotFlag[g])
			);
		end
	endgenerate
	always @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg <= 3'h0;
			sleep_reg <= 11'h000;
			wake_reg <= 11'h000;
			trig_reg <= 11'h000;
			maxAuto_reg <= 11'h000;
			txStart_reg <= 11'h000;
			slotNudge_reg <= 12'h000;
			sampNudge_reg <= 11'h000;
			nudgePend_reg <= 1'b0;
			rx1Ctl_reg <= 2'h0;
			rx2Ctl_reg <= 2'h0;
			slot_reg <= 12'h000;
			sample_reg <= 11'h000;
			tick_reg <= 8'h00;
			flag1_reg <= 23'h000000;
			flag2_reg <= 23'h000000;
			autoNudge_reg <= 12'h000;
			autoPend_reg <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rfEnableCh1 <= 1'b0;
			rfEnableCh2 <= 1'b0;
			rxActiveCh1 <= 1'b0;
			rxActiveCh2 <= 1'b0;
			txStartPulse <= 1'b0;
		end else begin
			tick_reg <= tick ? 8'h00 : tick_reg + 8'h01;
			if (utcPulse && ctrl_reg[1:0] == `RXSN_MODE_TRACK) begin
				autoNudge_reg <= clamped;
				autoPend_reg <= 1'b1;
			end
			if (tick) begin
				if (atTrig) begin
					sample_reg <= sampSum[10:0];
					slot_reg <= slotSum[11] ?
						slotSum + `RXSN_SLOT_MAX + 12'd1 :
						(slotSum > `RXSN_SLOT_MAX ?
						slotSum - `RXSN_SLOT_MAX - 12'd1 : slotSum);
					slotNudge_reg <= 12'h000;
					sampNudge_reg <= 11'h000;
					nudgePend_reg <= 1'b0;
					autoPend_reg <= 1'b0;
				end else if (sample_reg == `RXSN_SAMPLE_MAX) begin
					sample_reg <= 11'h000;
					slot_reg <= (slot_reg == `RXSN_SLOT_MAX) ?
						12'h000 : slot_reg + 12'h001;
				end else
					sample_reg <= sample_reg + 11'h001;
			end
			// exact match start
			// First cycle of the start sample, not its last
			txStartPulse <= (tick_reg == 8'h00) &&
				(sample_reg == txStart_reg);
			if (ch1FlagDet)
				flag1_reg <= {slot_reg, sample_reg};
			if (ch2FlagDet)
				flag2_reg <= {slot_reg, sample_reg};
			rfEnableCh1 <= rx1Ctl_reg[`RXSN_B_RXEN] & ~asleep[0];
			rfEnableCh2 <= rx2Ctl_reg[`RXSN_B_RXEN] & ~asleep[1];
			rxActiveCh1 <= gotFlag[0];
			rxActiveCh2 <= gotFlag[1];
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			if (apbWr) begin
				case (paddr)
				`RXSN_A_CTRL: ctrl_reg <= pwdata[2:0];
				`RXSN_A_SLEEP: sleep_reg <= pwdata[10:0];
				`RXSN_A_WAKE: wake_reg <= pwdata[10:0];
				`RXSN_A_TRIG: trig_reg <= pwdata[10:0];
				`RXSN_A_SLOTNDG: slotNudge_reg <= pwdata[11:0];
				`RXSN_A_SAMPNDG: begin
					sampNudge_reg <= pwdata[10:0];
					nudgePend_reg <= 1'b1;
				end
				`RXSN_A_MAXAUTO: maxAuto_reg <= pwdata[10:0];
				`RXSN_A_TXSTART: txStart_reg <= pwdata[10:0];
				`RXSN_A_RX1CTL: rx1Ctl_reg <= pwdata[1:0];
				`RXSN_A_RX2CTL: rx2Ctl_reg <= pwdata[1:0];
				default: pslverr <= 1'b1;
				endcase
			end
			if (apbRd) begin
				case (paddr)
				`RXSN_A_CTRL: prdata <= {29'h0, ctrl_reg};
				`RXSN_A_SLEEP: prdata <= {21'h0, sleep_reg};
				`RXSN_A_WAKE: prdata <= {21'h0, wake_reg};
				`RXSN_A_TRIG: prdata <= {21'h0, trig_reg};
				`RXSN_A_SLOTNDG: prdata <= {20'h0, slotNudge_reg};
				`RXSN_A_SAMPNDG: prdata <= {21'h0, sampNudge_reg};
				`RXSN_A_MAXAUTO: prdata <= {21'h0, maxAuto_reg};
				`RXSN_A_TXSTART: prdata <= {21'h0, txStart_reg};
				`RXSN_A_RX1CTL: prdata <= {30'h0, rx1Ctl_reg};
				`RXSN_A_RX2CTL: prdata <= {30'h0, rx2Ctl_reg};
				`RXSN_A_COUNT: prdata <= {4'h0, slot_reg, 5'h00, sample_reg};
				`RXSN_A_CH1FLAG: prdata <= {4'h0, flag1_reg[22:11],
					5'h00, flag1_reg[10:0]};
				`RXSN_A_CH2FLAG: prdata <= {4'h0, flag2_reg[22:11],
					5'h00, flag2_reg[10:0]};
				`RXSN_A_STATUS: prdata <= {28'h0, gotFlag, asleep};
				default: prdata <= 32'h00000000;
				endcase
			end
			if (psel && penable && !pwrite && !pready &&
				paddr > `RXSN_A_STATUS)
				pslverr <= 1'b1;
		end
	end
endmodule // rxsn_slot_timer

/* rtl/rxsn_defs.vh */
`ifndef RXSN_DEFS_VH
`define RXSN_DEFS_VH
`define RXSN_SLOT_MAX 12'd2249
`define RXSN_SAMPLE_MAX 11'd1279
`define RXSN_TICK_NS 32'd2000
`define RXSN_CLK_NS 32'd10
`define RXSN_TICK_CYC (`RXSN_TICK_NS / `RXSN_CLK_NS)
`define RXSN_TICK_LAST 8'd199
`define RXSN_A_CTRL 12'h000
`define RXSN_A_SLEEP 12'h004
`define RXSN_A_WAKE 12'h008
`define RXSN_A_TRIG 12'h00C
`define RXSN_A_SLOTNDG 12'h010
`define RXSN_A_SAMPNDG 12'h014
`define RXSN_A_MAXAUTO 12'h018
`define RXSN_A_TXSTART 12'h01C
`define RXSN_A_RX1CTL 12'h020
`define RXSN_A_RX2CTL 12'h024
`define RXSN_A_COUNT 12'h028
`define RXSN_A_CH1FLAG 12'h02C
`define RXSN_A_CH2FLAG 12'h030
`define RXSN_A_STATUS 12'h034
`define RXSN_B_SLEEPEN 2
`define RXSN_B_MODE_HI 1
`define RXSN_B_MODE_LO 0
`define RXSN_B_RXEN 0
`define RXSN_B_AIS 1
`define RXSN_MODE_TRACK 2'b10
`endif

/* rtl/rxsn_chan_sleep.v */
`timescale 1ns/100ps
`include "rxsn_defs.vh"
module rxsn_chan_sleep (
	input wire mclk,
	input wire rst_n,
	input wire sleepOn,
	input wire [1:0] chanCtl,
	input wire slotStart,
	input wire flagDet,
	input wire [10:0] sampleCount,
	input wire [10:0] sleepSample,
	input wire [10:0] wakeSample,
	output reg asleep_reg,
	output reg gotFlag_reg
);
	wire chanUsed;
	assign chanUsed = chanCtl[`RXSN_B_RXEN] & chanCtl[`RXSN_B_AIS];
	always @(posedge mclk) begin
		if (!rst_n) begin
			asleep_reg <= 1'b0;
			gotFlag_reg <= 1'b0;
		end else begin
			if (flagDet)
				gotFlag_reg <= 1'b1;
			else if (slotStart)
				gotFlag_reg <= 1'b0;
			if (asleep_reg && sampleCount == wakeSample)
				asleep_reg <= 1'b0;
			else if (!sleepOn || !chanUsed)
				asleep_reg <= 1'b0;
			else if (!asleep_reg && sampleCount == sleepSample
				&& !gotFlag_reg && !flagDet)
				asleep_reg <= 1'b1;
		end
	end
endmodule // rxsn_chan_sleep

/* verif/rxsn_rf_model.sv */
`timescale 1ns/100ps
module rxsn_rf_model (
	input wire mclk,
	input wire rfEnable,
	input wire fire,
	output reg flagDet
);
	initial flagDet = 1'b0;
	always @(posedge mclk)
		flagDet <= fire && rfEnable;
endmodule // rxsn_rf_model

/* verif/rxsn_timer_monitor.sv */
`timescale 1ns/100ps
module rxsn_timer_monitor (
	input wire mclk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire ch1FlagDet,
	input wire ch2FlagDet,
	input wire rfEnableCh1,
	input wire rfEnableCh2,
	input wire rxActiveCh1,
	input wire rxActiveCh2,
	input wire txStartPulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_tx_single: assert property (txStartPulse |=> !txStartPulse[*8])
		else $error("tx start repeated");
	a_flag_seen1: assert property (ch1FlagDet && rfEnableCh1 |-> ##[1:3] rxActiveCh1)
		else $error("ch1 flag lost");
	a_flag_seen2: assert property (ch2FlagDet && rfEnableCh2 |-> ##[1:3] rxActiveCh2)
		else $error("ch2 flag lost");
	a_keep_rf1: assert property (rxActiveCh1 && rfEnableCh1 && !psel |=> rfEnableCh1 || !rxActiveCh1)
		else $error("ch1 slept while active");
	a_keep_rf2: assert property (rxActiveCh2 && rfEnableCh2 && !psel |=> rfEnableCh2 || !rxActiveCh2)
		else $error("ch2 slept while active");
endmodule // rxsn_timer_monitor
bind rxsn_slot_timer rxsn_timer_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.ch1FlagDet(ch1FlagDet), .ch2FlagDet(ch2FlagDet),
	.rfEnableCh1(rfEnableCh1), .rfEnableCh2(rfEnableCh2),
	.rxActiveCh1(rxActiveCh1), .rxActiveCh2(rxActiveCh2),
	.txStartPulse(txStartPulse));

/* verif/tb.sv */
`timescale 1ns/100ps
`include "rxsn_defs.vh"
module tb;
	reg mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	reg pwrite = 1'b0, fire1 = 1'b0, fire2 = 1'b0, armed = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, flag1, flag2, rf1, rf2, act1, act2, txPulse;
	integer failures = 0, compares = 0, cyc = 0, txs = 0, txSeen = 0, i;
	reg [32:0] expQ [$];
	rxsn_slot_timer i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ch1FlagDet(flag1), .ch2FlagDet(flag2),
		.utcPulse(1'b0), .rfEnableCh1(rf1), .rfEnableCh2(rf2),
		.rxActiveCh1(act1), .rxActiveCh2(act2), .txStartPulse(txPulse));
	rxsn_rf_model i_rf1 (.mclk(mclk), .rfEnable(rf1), .fire(fire1),
		.flagDet(flag1));
	rxsn_rf_model i_rf2 (.mclk(mclk), .rfEnable(rf2), .fire(fire2),
		.flagDet(flag2));
	initial forever #5 mclk = ~mclk;
	task end_of_test;
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input [32:0] e, input [32:0] g);
		compares = compares + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
		integer n;
		@(posedge mclk);
		if (!w)
			expQ.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures = failures + 1;
			end_of_test;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task waitc(input integer n);
		while (cyc < n)
			@(posedge mclk);
	endtask
	// Scoreboard side, notes taken oldest first
	always @(posedge mclk) begin
		if (rst_n)
			cyc <= cyc + 1;
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("apbRead", expQ.pop_front(), {pslverr, prdata});
		if (armed && txPulse === 1'b1) begin
			txSeen = txSeen + 1;
			chk("txSample", txs, cyc / 200);
		end
	end
	initial begin
		i = $urandom(93);
		txs = 14 + $urandom % 10;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		apb(1'b1, `RXSN_A_RX1CTL, 32'h3, 33'h0);
		apb(1'b1, `RXSN_A_RX2CTL, 32'h3, 33'h0);
		apb(1'b1, `RXSN_A_SLEEP, 32'h3, 33'h0);
		apb(1'b1, `RXSN_A_WAKE, 32'h6, 33'h0);
		apb(1'b1, `RXSN_A_TXSTART, txs, 33'h0);
		armed <= 1'b1;
		waitc(300);
		fire1 <= 1'b1;
		@(posedge mclk);
		fire1 <= 1'b0;
		waitc(900);
		chk("rf2", 33'h1, rf2);
		// sleep after flag point, wake soon after
		apb(1'b1, `RXSN_A_SLEEP, 32'h8, 33'h0);
		apb(1'b1, `RXSN_A_WAKE, 32'hB, 33'h0);
		// no nudges, so no count is skipped
		apb(1'b1, `RXSN_A_CTRL, 32'h4, 33'h0);
		waitc(1900);
		chk("rf1", 33'h1, rf1);
		chk("rf2", 33'h0, rf2);
		chk("act1", 33'h1, act1);
		chk("act2", 33'h0, act2);
		apb(1'b0, `RXSN_A_STATUS, 32'h0, 33'h6);
		apb(1'b0, `RXSN_A_CH1FLAG, 32'h0, 33'h1);
		apb(1'b0, `RXSN_A_CH2FLAG, 32'h0, 33'h0);
		apb(1'b0, 12'h040, 32'h0, 33'h100000000);
		waitc(2500);
		chk("rf2", 33'h1, rf2);
		waitc(4700);
		// nudge at trigger, slot wraps below 0
		apb(1'b1, `RXSN_A_TRIG, 32'd25, 33'h0);
		apb(1'b1, `RXSN_A_SLOTNDG, 32'hFFF, 33'h0);
		apb(1'b1, `RXSN_A_SAMPNDG, 32'h5, 33'h0);
		waitc(5300);
		apb(1'b0, `RXSN_A_COUNT, 32'h0, 33'h08C9001F);
		apb(1'b0, `RXSN_A_SAMPNDG, 32'h0, 33'h0);
		waitc(6200);
		chk("txSeen", 33'h1, txSeen);
		end_of_test;
	end
endmodule // tb
